// *** usmp_pkg.sv ***
// usmp_pkg: constants shared by the serial and modem pin logic of both channels
// assumes one 250 MHz clock (mclk) and a synchronous active-low reset
package usmp_pkg;

  // register port geometry
  localparam int unsigned ADDR_W       = 4;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned CHAN_BIT     = 3;      // address bit that picks the channel
  localparam int unsigned NUM_CHAN     = 2;

  // register offsets inside one channel bank
  localparam logic [2:0] OFS_MODEM_CTL = 3'h0;   // modem_control_reg
  localparam logic [2:0] OFS_INT_EN    = 3'h1;   // interrupt_enable_reg
  localparam logic [2:0] OFS_ENH_FEAT  = 3'h2;   // enhanced_feature_reg
  localparam logic [2:0] OFS_ALT_FUNC  = 3'h3;   // alternate_function_reg
  localparam logic [2:0] OFS_DIV_LO    = 3'h4;   // baud divisor, low byte
  localparam logic [2:0] OFS_DIV_HI    = 3'h5;   // baud divisor, high byte
  localparam logic [2:0] OFS_MODEM_STS = 3'h6;   // modem input levels and deltas
  localparam logic [2:0] OFS_PIN_STS   = 3'h7;   // readback of driven pins

  // modem_control_reg fields
  localparam int unsigned MCR_TERM_RDY = 0;
  localparam int unsigned MCR_REQ_SEND = 1;
  localparam int unsigned MCR_GEN_OUT2 = 3;
  localparam int unsigned MCR_IR_MODE  = 6;
  // enhanced_feature_reg fields
  localparam int unsigned EFR_AUTO_RTS = 6;
  localparam int unsigned EFR_AUTO_CTS = 7;
  // interrupt_enable_reg fields
  localparam int unsigned IER_RTS_EN   = 6;
  localparam int unsigned IER_CTS_EN   = 7;
  // alternate_function_reg fields
  localparam int unsigned AFR_BCAST    = 0;
  localparam int unsigned AFR_MF_LSB   = 1;      // two-bit field, bits 1-2
  localparam int unsigned AFR_IR_INV   = 4;      // invert infrared receive input

  // multi-function pin selection
  typedef enum logic [1:0] {
    MF_GEN_OUT2 = 2'h0,
    MF_BAUD_CLK = 2'h1,
    MF_RX_READY = 2'h2,
    MF_SPARE    = 2'h3
  } usmp_mf_sel_t;

  // reset values
  localparam logic [7:0]  RST_REG8     = 8'h00;
  localparam logic [15:0] RST_DIVISOR  = 16'h0001;
  localparam logic [3:0]  RST_MODEM_IN = 4'hf;   // inactive (high) modem inputs

  // timing
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned RESET_MIN_NS  = 40;
  localparam int unsigned RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// *** usmp_chan_if.sv ***
// usmp_chan_if: control bundle from one channel's register bank to its pin and baud logic
// assumes every member is driven in the mclk domain
`timescale 1ns/1ns
interface usmp_chan_if;
  logic [7:0]  modemCtl;     // modem_control_reg
  logic [7:0]  intEn;        // interrupt_enable_reg
  logic [7:0]  enhFeat;      // enhanced_feature_reg
  logic [7:0]  altFunc;      // alternate_function_reg
  logic [15:0] divisor;      // baud divisor
  logic        baudClk;      // baud rate clock level
  logic        baudTick;     // one-cycle pulse per baud period

  // register bank side
  modport regs (output modemCtl, output intEn, output enhFeat, output altFunc, output divisor,
                input baudClk, input baudTick);
  // baud generator side
  modport baud (input divisor, output baudClk, output baudTick);
  // pin logic side
  modport pins (input modemCtl, input intEn, input enhFeat, input altFunc, input baudClk);
endinterface

// *** usmp_baud_gen.sv ***
// usmp_baud_gen: divides mclk by the channel divisor into a baud clock and tick
// assumes divisor is stable between writes; zero is treated as one
`timescale 1ns/1ns
module usmp_baud_gen (
  input  wire logic mclk,
  input  wire logic rst_n,
  usmp_chan_if.baud bus
);
  logic [15:0] cnt_ff;       // down counter inside one baud period
  logic [15:0] nxt_cnt;
  logic        clk_ff;       // baud clock level
  logic        nxt_clk;
  logic        tick_ff;      // end-of-period pulse
  logic        nxt_tick;
  logic [15:0] half;         // point where the clock goes high

  // next counter and clock values
  always_comb
  begin
    half     = bus.divisor >> 1;
    nxt_tick = 1'b0;
    nxt_cnt  = cnt_ff - 16'h0001;
    nxt_clk  = clk_ff;
    if (cnt_ff <= 16'h0001)
    begin
      // reload; a divisor of zero would stall, so it runs as one
      nxt_cnt  = (bus.divisor == 16'h0000) ? 16'h0001 : bus.divisor;
      nxt_tick = 1'b1;
      nxt_clk  = 1'b0;
    end
    else if (cnt_ff <= half)
    begin
      nxt_clk = 1'b1;
    end
  end

  // registers only
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cnt_ff  <= usmp_pkg::RST_DIVISOR;
      clk_ff  <= 1'b0;
      tick_ff <= 1'b0;
    end
    else
    begin
      cnt_ff  <= nxt_cnt;
      clk_ff  <= nxt_clk;
      tick_ff <= nxt_tick;
    end
  end

  assign bus.baudClk  = clk_ff;
  assign bus.baudTick = tick_ff;
endmodule

// *** usmp_pin_mux.sv ***
// usmp_pin_mux: per-channel serial and modem pin drive, registered
// assumes the core gives a standard tx level (idle high) and an infrared pulse (idle low)
`timescale 1ns/1ns
module usmp_pin_mux (
  input  wire logic mclk,
  input  wire logic rst_n,
  usmp_chan_if.pins ctl,
  input  wire logic coreTxSerial,
  input  wire logic coreTxIrPulse,
  input  wire logic coreRxAboveTrigger,
  input  wire logic coreRxDataReady,
  input  wire logic serialIn,
  input  wire logic clearToSendIn_n,
  output logic      serialOut,
  output logic      requestToSendOut_n,
  output logic      terminalReadyOut_n,
  output logic      multiFunctionOut_n,
  output logic      coreRxLine,
  output logic      coreTxHalt
);
  logic irMode;              // infrared encoder and decoder selected
  logic autoRts;             // automatic request-to-send active
  logic autoCts;             // automatic clear-to-send active
  usmp_pkg::usmp_mf_sel_t mfSel;
  logic tx_ff, nxt_tx;
  logic rts_ff, nxt_rts;
  logic dtr_ff, nxt_dtr;
  logic mf_ff, nxt_mf;
  logic rx_ff, nxt_rx;
  logic halt_ff, nxt_halt;

  // next pin values
  always_comb
  begin
    irMode  = ctl.modemCtl[usmp_pkg::MCR_IR_MODE];
    autoRts = ctl.enhFeat[usmp_pkg::EFR_AUTO_RTS] & ctl.intEn[usmp_pkg::IER_RTS_EN];
    autoCts = ctl.enhFeat[usmp_pkg::EFR_AUTO_CTS] & ctl.intEn[usmp_pkg::IER_CTS_EN];
    mfSel   = usmp_pkg::usmp_mf_sel_t'(ctl.altFunc[usmp_pkg::AFR_MF_LSB +: 2]);
    // standard idles high, infrared idles low
    nxt_tx  = irMode ? coreTxIrPulse : coreTxSerial;
    // inversion sits ahead of the decoder; standard path passes untouched
    nxt_rx  = irMode ? (serialIn ^ ctl.altFunc[usmp_pkg::AFR_IR_INV]) : serialIn;
    // auto flow only withdraws a request that software has already made
    nxt_rts = ~(ctl.modemCtl[usmp_pkg::MCR_REQ_SEND] & ~(autoRts & coreRxAboveTrigger));
    nxt_halt = autoCts & clearToSendIn_n;
    nxt_dtr = ~ctl.modemCtl[usmp_pkg::MCR_TERM_RDY];
    case (mfSel)
      usmp_pkg::MF_GEN_OUT2: nxt_mf = ~ctl.modemCtl[usmp_pkg::MCR_GEN_OUT2];
      usmp_pkg::MF_BAUD_CLK: nxt_mf = ctl.baudClk;
      usmp_pkg::MF_RX_READY: nxt_mf = ~coreRxDataReady;
      default:               nxt_mf = 1'b1;  // spare code parks the pin inactive
    endcase
  end

  // registers only; reset parks tx high and rx at standard idle
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      tx_ff   <= 1'b1;
      rx_ff   <= 1'b1;
      rts_ff  <= 1'b1;
      dtr_ff  <= 1'b1;
      mf_ff   <= 1'b1;
      halt_ff <= 1'b0;
    end
    else
    begin
      tx_ff   <= nxt_tx;
      rx_ff   <= nxt_rx;
      rts_ff  <= nxt_rts;
      dtr_ff  <= nxt_dtr;
      mf_ff   <= nxt_mf;
      halt_ff <= nxt_halt;
    end
  end

  assign serialOut          = tx_ff;
  assign coreRxLine         = rx_ff;
  assign requestToSendOut_n = rts_ff;
  assign terminalReadyOut_n = dtr_ff;
  assign multiFunctionOut_n = mf_ff;
  assign coreTxHalt         = halt_ff;
endmodule

// *** usmp_top.sv ***
// usmp_top: serial and modem pin logic for both channels with their control registers
// assumes a simple register port (read data one cycle later) and a UART core per channel
// Function
// - standard mode: tx high in reset, idle
// - infrared mode: interface idles low
// - software inversion of infrared rx before decoder
// - request-to-send is general output, auto flow
// - clear-to-send general input, auto flow usable
// - set-ready, carrier, ring inputs: status only
// - terminal-ready active low, software driven
// - multi-function pin: one of three functions
// - general output two low when bit set
// - general output two bit resets to zero
// - baud clock function drives baud clock
// - receive-ready function: active-low receiver status
// - reset clears registers except the divisor (loads one), tx high, rx ignored
`timescale 1ns/1ns
module usmp_top (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [7:0]  regRdData,
  input  wire logic [1:0]  coreTxSerial,
  input  wire logic [1:0]  coreTxIrPulse,
  input  wire logic [1:0]  coreRxAboveTrigger,
  input  wire logic [1:0]  coreRxDataReady,
  output logic      [1:0]  coreRxLine,
  output logic      [1:0]  coreTxHalt,
  output logic      [1:0]  coreBaudTick,
  input  wire logic        serialInFirstChannel,
  input  wire logic        serialInSecondChannel,
  output logic             serialOutFirstChannel,
  output logic             serialOutSecondChannel,
  output logic      [1:0]  requestToSendOut_n,
  input  wire logic [1:0]  clearToSendIn_n,
  output logic      [1:0]  terminalReadyOut_n,
  input  wire logic [1:0]  setReadyIn_n,
  input  wire logic [1:0]  carrierDetectIn_n,
  input  wire logic [1:0]  ringIndicatorIn_n,
  output logic      [1:0]  multiFunctionOut_n
);
  logic [1:0]  serialIn;         // receive pins gathered per channel
  logic [1:0]  serialOut;        // transmit pins gathered per channel
  logic [1:0]  broadcast;        // channel asks writes to reach both banks
  logic [7:0]  chanRd [2];       // per-channel read data
  logic [7:0]  rd_ff;            // read data register
  logic [7:0]  nxt_rd;

  // write hits this bank directly or by broadcast from either channel
  function automatic logic bankWrite(input logic [3:0] addr, input logic wr,
                                     input int unsigned ch, input logic bc);
    bankWrite = wr & ((addr[usmp_pkg::CHAN_BIT] == ch[0]) | bc);
  endfunction

  // read hits this bank only through its own select bit
  function automatic logic bankRead(input logic [3:0] addr, input logic rd,
                                    input int unsigned ch);
    bankRead = rd & (addr[usmp_pkg::CHAN_BIT] == ch[0]);
  endfunction

  // pins gathered per channel
  assign serialIn[0]            = serialInFirstChannel;
  assign serialIn[1]            = serialInSecondChannel;
  assign serialOutFirstChannel  = serialOut[0];
  assign serialOutSecondChannel = serialOut[1];

  // one bank and pin set per channel
  genvar gc;
  generate
    for (gc = 0; gc < usmp_pkg::NUM_CHAN; gc++)
    begin : g_chan
      usmp_chan_if chIf ();          // this channel's control bundle

      logic [7:0]  mcr_ff;           // modem_control_reg
      logic [7:0]  nxt_mcr;
      logic [7:0]  ier_ff;           // interrupt_enable_reg
      logic [7:0]  nxt_ier;
      logic [7:0]  efr_ff;           // enhanced_feature_reg
      logic [7:0]  nxt_efr;
      logic [7:0]  afr_ff;           // alternate_function_reg
      logic [7:0]  nxt_afr;

      logic [15:0] div_ff;           // baud divisor
      logic [15:0] nxt_div;

      logic [3:0]  prev_ff;          // last sampled modem inputs, {cd,ri,dsr,cts}
      logic [3:0]  nxt_prev;
      logic [3:0]  delta_ff;         // sticky change flags
      logic [3:0]  nxt_delta;

      logic [3:0]  modemIn;          // raw modem inputs, active low
      logic [3:0]  change;           // change events this cycle

      logic        wrHit;
      logic        rdHit;

      // control register next values
      always_comb
      begin
        wrHit   = bankWrite(regAddr, regWrite, gc, broadcast[0] | broadcast[1]);

        // hold unless written
        nxt_mcr = mcr_ff;
        nxt_ier = ier_ff;
        nxt_efr = efr_ff;
        nxt_afr = afr_ff;
        nxt_div = div_ff;
        if (wrHit)
        begin
          // decode of the low address bits within the bank
          if (regAddr[2:0] == usmp_pkg::OFS_MODEM_CTL)
          begin
            nxt_mcr = regWrData;
          end
          else if (regAddr[2:0] == usmp_pkg::OFS_INT_EN)
          begin
            nxt_ier = regWrData;
          end
          else if (regAddr[2:0] == usmp_pkg::OFS_ENH_FEAT)
          begin
            nxt_efr = regWrData;
          end
          else if (regAddr[2:0] == usmp_pkg::OFS_ALT_FUNC)
          begin
            nxt_afr = regWrData;
          end
          // bytes land independently
          else if (regAddr[2:0] == usmp_pkg::OFS_DIV_LO)
          begin
            nxt_div = {div_ff[15:8], regWrData};
          end
          else if (regAddr[2:0] == usmp_pkg::OFS_DIV_HI)
          begin
            nxt_div = {regWrData, div_ff[7:0]};
          end
          // status offsets are read-only; writes there are dropped
        end
      end

      // control registers only
      always_ff @(posedge mclk)
      begin
        if (!rst_n)
        begin
          // mf pin starts inactive
          mcr_ff <= usmp_pkg::RST_REG8;
          ier_ff <= usmp_pkg::RST_REG8;
          efr_ff <= usmp_pkg::RST_REG8;
          afr_ff <= usmp_pkg::RST_REG8;
          div_ff <= usmp_pkg::RST_DIVISOR;
        end
        else
        begin
          mcr_ff <= nxt_mcr;
          ier_ff <= nxt_ier;
          efr_ff <= nxt_efr;
          afr_ff <= nxt_afr;
          div_ff <= nxt_div;
        end
      end

      // modem input tracking; these inputs feed status only, except cts, which also drives the auto-cts transmit halt
      always_comb
      begin
        modemIn   = {carrierDetectIn_n[gc], ringIndicatorIn_n[gc],
                     setReadyIn_n[gc], clearToSendIn_n[gc]};
        rdHit     = bankRead(regAddr, regRead, gc);
        change    = modemIn ^ prev_ff;
        // ring flag only on the trailing edge, when the pin returns high
        change[2] = modemIn[2] & ~prev_ff[2];
        nxt_prev  = modemIn;

        nxt_delta = delta_ff;
        if (rdHit && (regAddr[2:0] == usmp_pkg::OFS_MODEM_STS))
        begin
          nxt_delta = 4'h0;          // read clears
        end
        nxt_delta = nxt_delta | change; // a change in the clear cycle survives
      end

      // modem tracking registers only
      always_ff @(posedge mclk)
      begin
        if (!rst_n)
        begin
          prev_ff  <= usmp_pkg::RST_MODEM_IN;
          delta_ff <= 4'h0;
        end
        else
        begin
          prev_ff  <= nxt_prev;
          delta_ff <= nxt_delta;
        end
      end

      // read mux for this bank
      always_comb
      begin
        if (regAddr[2:0] == usmp_pkg::OFS_MODEM_CTL)
        begin
          chanRd[gc] = mcr_ff;
        end
        else if (regAddr[2:0] == usmp_pkg::OFS_INT_EN)
        begin
          chanRd[gc] = ier_ff;
        end
        else if (regAddr[2:0] == usmp_pkg::OFS_ENH_FEAT)
        begin
          chanRd[gc] = efr_ff;
        end
        else if (regAddr[2:0] == usmp_pkg::OFS_ALT_FUNC)
        begin
          chanRd[gc] = afr_ff;
        end
        else if (regAddr[2:0] == usmp_pkg::OFS_DIV_LO)
        begin
          chanRd[gc] = div_ff[7:0];
        end
        else if (regAddr[2:0] == usmp_pkg::OFS_DIV_HI)
        begin
          chanRd[gc] = div_ff[15:8];
        end

        else if (regAddr[2:0] == usmp_pkg::OFS_MODEM_STS)
        begin
          // upper nibble shows inputs as asserted-high
          chanRd[gc] = {~prev_ff, delta_ff};
        end
        else
        begin
          // pin readback: what this channel is driving right now
          chanRd[gc] = {4'h0, multiFunctionOut_n[gc], terminalReadyOut_n[gc],
                        requestToSendOut_n[gc], serialOut[gc]};
        end
      end

      // bundle towards baud and pins
      assign broadcast[gc]     = afr_ff[usmp_pkg::AFR_BCAST];
      assign chIf.modemCtl     = mcr_ff;
      assign chIf.intEn        = ier_ff;
      assign chIf.enhFeat      = efr_ff;
      assign chIf.altFunc      = afr_ff;
      assign chIf.divisor      = div_ff;
      assign coreBaudTick[gc]  = chIf.baudTick;

      // baud rate clock for this channel
      usmp_baud_gen u_baud (
        .mclk  (mclk),
        .rst_n (rst_n),
        .bus   (chIf.baud)
      );

      // pin drive for this channel; standard rx is the far end's to keep idle high, infrared rx can be inverted by software
      usmp_pin_mux u_pins (
        .mclk               (mclk),
        .rst_n              (rst_n),
        .ctl                (chIf.pins),
        .coreTxSerial       (coreTxSerial[gc]),
        .coreTxIrPulse      (coreTxIrPulse[gc]),
        .coreRxAboveTrigger (coreRxAboveTrigger[gc]),
        .coreRxDataReady    (coreRxDataReady[gc]),
        .serialIn           (serialIn[gc]),
        .clearToSendIn_n    (clearToSendIn_n[gc]),
        .serialOut          (serialOut[gc]),
        .requestToSendOut_n (requestToSendOut_n[gc]),
        .terminalReadyOut_n (terminalReadyOut_n[gc]),
        .multiFunctionOut_n (multiFunctionOut_n[gc]),
        .coreRxLine         (coreRxLine[gc]),
        .coreTxHalt         (coreTxHalt[gc])
      );
    end
  endgenerate

  // read data pick; idle cycles return zero
  always_comb
  begin
    nxt_rd = 8'h00;
    if (regRead)
    begin
      // the channel bit picks the bank
      nxt_rd = chanRd[regAddr[usmp_pkg::CHAN_BIT]];
    end
  end

  // read data register only
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      // no stale data after reset
      rd_ff <= 8'h00;
    end
    else
    begin
      rd_ff <= nxt_rd;
    end
  end

  assign regRdData = rd_ff;
endmodule

// *** usmp_far_end.sv ***
// usmp_far_end: line transceiver and modem seen from both channels' pins
// assumes the bench hands fresh random bits on noise once per stimulus loop iteration
`timescale 1ns/1ns
module usmp_far_end (
  input  wire logic [1:0] irMode,
  input  wire logic [1:0] framing,
  input  wire logic [9:0] noise,
  output logic            serialInFirstChannel,
  output logic            serialInSecondChannel,
  output logic      [1:0] clearToSendIn_n,
  output logic      [1:0] setReadyIn_n,
  output logic      [1:0] carrierDetectIn_n,
  output logic      [1:0] ringIndicatorIn_n
);
  // line idles high in standard mode, low in infrared mode; data only inside a character
  always_comb
  begin
    serialInFirstChannel  = framing[0] ? noise[0] : ~irMode[0];
    serialInSecondChannel = framing[1] ? noise[1] : ~irMode[1];
    // modem lines wander freely; only cts steers the uart, through the auto-cts transmit halt
    {clearToSendIn_n, setReadyIn_n, carrierDetectIn_n, ringIndicatorIn_n} = noise[9:2];
  end
endmodule

// *** usmp_top_sva.sv ***
// usmp_top_sva: pin checks for usmp_top, bound from this file
// assumes binding into usmp_top, one mclk domain
`timescale 1ns/1ns
module usmp_chk (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regRdData,
  input wire logic [1:0] coreTxSerial,
  input wire logic [1:0] coreTxIrPulse,
  input wire logic [1:0] coreRxAboveTrigger,
  input wire logic [1:0] coreRxDataReady,
  input wire logic [1:0] coreRxLine,
  input wire logic [1:0] coreTxHalt,
  input wire logic       serialInFirstChannel,
  input wire logic       serialInSecondChannel,
  input wire logic       serialOutFirstChannel,
  input wire logic       serialOutSecondChannel,
  input wire logic [1:0] requestToSendOut_n,
  input wire logic [1:0] clearToSendIn_n,
  input wire logic [1:0] terminalReadyOut_n,
  input wire logic [1:0] multiFunctionOut_n
);
  logic [7:0] shadow_ff  [2][4]; // mirror of control regs
  logic [7:0] nxt_shadow [2][4];
  logic [1:0] txPins, rxPins, txExp, rxExp, rtsExp, haltExp, dtrExp, mfExp, mfCare;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // shadow follows writes; broadcast from either afr bit0 hits both banks
  always_comb
  begin
    nxt_shadow = shadow_ff;
    for (int c = 0; c < 2; c++)
      if (regWrite && !regAddr[2] && (regAddr[3] == c[0] || shadow_ff[0][3][0] || shadow_ff[1][3][0]))
        nxt_shadow[c][regAddr[1:0]] = regWrData;
  end
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      shadow_ff <= '{default: 8'h00};
    else
      shadow_ff <= nxt_shadow;
  end

  // expected pins, one edge ahead
  always_comb
  begin
    txPins = {serialOutSecondChannel, serialOutFirstChannel};
    rxPins = {serialInSecondChannel, serialInFirstChannel};
    for (int c = 0; c < 2; c++)
    begin
      txExp[c]   = shadow_ff[c][0][6] ? coreTxIrPulse[c] : coreTxSerial[c];
      rxExp[c]   = shadow_ff[c][0][6] ? rxPins[c] ^ shadow_ff[c][3][4] : rxPins[c];
      rtsExp[c]  = ~(shadow_ff[c][0][1] & ~(shadow_ff[c][2][6] & shadow_ff[c][1][6] & coreRxAboveTrigger[c]));
      haltExp[c] = shadow_ff[c][2][7] & shadow_ff[c][1][7] & clearToSendIn_n[c];
      dtrExp[c]  = ~shadow_ff[c][0][0];
      // baud code is checked by the bench
      mfCare[c]  = shadow_ff[c][3][2:1] != 2'h1;
      mfExp[c]   = shadow_ff[c][3][2] ? (shadow_ff[c][3][1] | ~coreRxDataReady[c]) : ~shadow_ff[c][0][3];
    end
  end

  chk_reset_pins: assert property (disable iff (1'b0) !rst_n |=> txPins == 2'h3 && requestToSendOut_n == 2'h3)
    else $error("tx or rts not high after reset");
  chk_rx_ignored: assert property (disable iff (1'b0) !rst_n |=> coreRxLine == 2'h3 && coreTxHalt == 2'h0)
    else $error("receive path not ignored in reset");
  chk_mf_release: assert property (disable iff (1'b0) $rose(rst_n) |=> multiFunctionOut_n == 2'h3 ##1 1'b1)
    else $error("mf pin not high after reset");
  chk_tx_select: assert property (rst_n |=> txPins == $past(txExp))
    else $error("tx pin wrong");
  chk_rx_invert: assert property (rst_n |=> coreRxLine == $past(rxExp))
    else $error("receive line polarity wrong");
  chk_rts_auto: assert property (rst_n |=> requestToSendOut_n == $past(rtsExp))
    else $error("request to send level wrong");
  chk_cts_halt: assert property (rst_n |=> coreTxHalt == $past(haltExp))
    else $error("clear to send halt wrong");
  chk_dtr_level: assert property (rst_n |=> terminalReadyOut_n == $past(dtrExp))
    else $error("terminal ready level wrong");
  chk_mf_select: assert property (rst_n |=> ((multiFunctionOut_n ^ $past(mfExp)) & $past(mfCare)) == 2'h0)
    else $error("multi function pin wrong");
  chk_rd_idle: assert property (!regRead |=> regRdData == 8'h00)
    else $error("read data not zero outside read");

  cover property (shadow_ff[0][0][6] && shadow_ff[0][3][4]);
  cover property (shadow_ff[1][3][2:1] == 2'h1);
  cover property (shadow_ff[1][0][1] && requestToSendOut_n[1]);
endmodule

bind usmp_top usmp_chk i_usmp_chk (.*);

// *** tb_top.sv ***
// tb_top: self-checking bench for usmp_top with a far-end line model
// assumes the checker binds itself and mclk is 4 ns
`timescale 1ns/1ns
module tb_top;
  logic       mclk, rst_n, regWrite, regRead;
  logic [3:0] regAddr;
  logic [7:0] regWrData, regRdData;
  logic [1:0] coreTxSerial, coreTxIrPulse, coreRxAboveTrigger, coreRxDataReady;
  logic [1:0] coreRxLine, coreTxHalt, coreBaudTick, requestToSendOut_n, terminalReadyOut_n;
  logic [1:0] clearToSendIn_n, setReadyIn_n, carrierDetectIn_n, ringIndicatorIn_n, multiFunctionOut_n;
  logic       serialInFirstChannel, serialInSecondChannel, serialOutFirstChannel, serialOutSecondChannel;
  logic [1:0] irMode, framing, mfMask; // far-end controls, mf care mask
  logic [9:0] noise; // random bits for far end
  logic [7:0] shv [2][4]; // expected control regs
  logic       lastMf;
  int         seed = 38703;
  int         mismatches, checks, ticks, flips;

  usmp_top i_usmp_top (.*);
  usmp_far_end i_usmp_far_end (.*);

  // free-running 250 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic close_out;
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected reg at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_pin(input logic [1:0] got, input logic [1:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected pin at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe, released at the next edge
  task automatic wr(input int c, input int o, input logic [7:0] d);
    @(posedge mclk);
    regWrite  <= 1'b1;
    regAddr   <= 4'(c * 8 + o);
    regWrData <= d;
    @(posedge mclk);
    regWrite  <= 1'b0;
  endtask

  // read data is looked at only in the cycle after the strobe
  task automatic rd(input int c, input int o, input logic [7:0] exp, input logic [7:0] mask);
    @(posedge mclk);
    regRead <= 1'b1;
    regAddr <= 4'(c * 8 + o);
    @(posedge mclk);
    regRead <= 1'b0;
    #1;
    cmp_reg(regRdData & mask, exp & mask);
  endtask

  // expected registered pins per kind: tx, rx, rts, halt, dtr, mf
  function automatic logic [1:0] expect_pin(input int k);
    logic [1:0] r;
    logic [1:0] rx;
    rx = {serialInSecondChannel, serialInFirstChannel};
    for (int c = 0; c < 2; c++)
      case (k)
        0: r[c] = shv[c][0][6] ? coreTxIrPulse[c] : coreTxSerial[c];
        1: r[c] = shv[c][0][6] ? rx[c] ^ shv[c][3][4] : rx[c];
        2: r[c] = ~(shv[c][0][1] & ~(shv[c][2][6] & shv[c][1][6] & coreRxAboveTrigger[c]));
        3: r[c] = shv[c][2][7] & shv[c][1][7] & clearToSendIn_n[c];
        4: r[c] = ~shv[c][0][0];
        default: r[c] = shv[c][3][2] ? (shv[c][3][1] | ~coreRxDataReady[c]) : ~shv[c][0][3];
      endcase
    return r;
  endfunction

  // hang guard, about nine times the run
  initial
  begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    close_out();
  end

  initial
  begin
    rst_n = 1'b0;
    {regWrite, regRead, regAddr, regWrData} = '0;
    {coreTxSerial, coreTxIrPulse, coreRxAboveTrigger, coreRxDataReady} = 8'hc0; // core idle
    {irMode, framing, noise} = 14'h03ff;
    repeat (10) @(posedge mclk);
    #1;
    cmp_pin({serialOutSecondChannel, serialOutFirstChannel}, 2'h3);
    cmp_pin(requestToSendOut_n & terminalReadyOut_n & multiFunctionOut_n, 2'h3);
    @(posedge mclk);
    rst_n <= 1'b1;
    for (int c = 0; c < 2; c++)
      rd(c, 0, 8'h00, 8'hff);
    // random control words, every mf code in turn, bit0 kept clear
    for (int it = 0; it < 60; it++)
    begin
      for (int c = 0; c < 2; c++)
        for (int o = 0; o < 4; o++)
        begin
          shv[c][o] = 8'($random(seed));
          if (o == 3)
            shv[c][o] = {shv[c][o][7:3], 2'(it + c), 1'b0};
          wr(c, o, shv[c][o]);
        end
      {coreTxSerial, coreTxIrPulse, coreRxAboveTrigger, coreRxDataReady} <= 8'($random(seed));
      irMode  <= {shv[1][0][6], shv[0][0][6]};
      framing <= 2'($random(seed));
      noise   <= 10'($random(seed));
      @(posedge mclk);
      #1;
      mfMask = {shv[1][3][2:1] != 2'h1, shv[0][3][2:1] != 2'h1};
      cmp_pin({serialOutSecondChannel, serialOutFirstChannel}, expect_pin(0));
      cmp_pin(coreRxLine, expect_pin(1));
      cmp_pin(requestToSendOut_n, expect_pin(2));
      cmp_pin(coreTxHalt, expect_pin(3));
      cmp_pin(terminalReadyOut_n, expect_pin(4));
      cmp_pin(multiFunctionOut_n & mfMask, expect_pin(5) & mfMask);
      for (int c = 0; c < 2; c++)
      begin
        rd(c, 6, {~carrierDetectIn_n[c], ~ringIndicatorIn_n[c], ~setReadyIn_n[c], ~clearToSendIn_n[c], 4'h0},
           8'hf0);
        for (int o = 0; o < 4; o++)
          rd(c, o, shv[c][o], 8'hff);
      end
    end
    // baud clock on channel 0 mf pin with divisor 4
    wr(0, 4, 8'h04);
    wr(0, 5, 8'h00);
    wr(0, 3, 8'h02);
    repeat (8) @(posedge mclk);
    #1;
    {ticks, flips} = '0;
    lastMf = multiFunctionOut_n[0];
    repeat (40)
    begin
      @(posedge mclk);
      #1;
      ticks += int'(coreBaudTick[0] === 1'b1);
      flips += int'(multiFunctionOut_n[0] !== lastMf);
      lastMf = multiFunctionOut_n[0];
    end
    cmp_reg(8'(ticks), 8'h0a);
    cmp_reg(8'(flips), 8'h14);
    // broadcast from bank 1 reaches both banks
    wr(1, 3, 8'h01);
    wr(0, 1, 8'h5a);
    rd(1, 1, 8'h5a, 8'hff);
    close_out();
  end
endmodule
